// file: core/supply_supervisor.sv
// supply supervisor: pushbutton reset, early warning, ram guard, seal and power-fail outputs
`timescale 1ns/1ps
`include "supervisor_consts.svh"
module supply_supervisor
  import supervisor_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // analog comparator results and board pins
  input wire logic i_pushbutton_reset_n,
  input wire logic i_mode_select,
  input wire logic i_sense_low,
  input wire logic i_sense_neg,
  input wire logic i_main_below_trip,
  input wire logic i_main_below_bat,
  input wire logic i_chip_sel_n,
  // processor outputs
  output logic o_reset,
  output logic o_reset_n,
  output logic o_warn_n,
  output logic o_warn_oe,
  // memory and power switching
  output logic o_chip_sel_out_n,
  output logic o_power_fail_flag,
  output logic o_power_fail_flag_n,
  output logic o_battery_sealed
);
  // two-flop synchronisers for all comparator and board pins; i_resetn stays asynchronous
  logic [7:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
  always_comb begin
    sync1_next = {i_pushbutton_reset_n, i_mode_select, i_sense_low, i_sense_neg,
                  i_main_below_trip, i_main_below_bat, i_chip_sel_n, 1'b0};
    sync2_next = sync1_reg;
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      // reset reads as a dead supply with idle pins: no false seal edge, no early arming
      sync1_reg <= 8'hce;
      sync2_reg <= 8'hce;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end
  logic pb_n, backed, sense_low, sense_neg, below_trip, below_bat, cs_in_n;
  assign pb_n = sync2_reg[7];
  assign backed = sync2_reg[6];
  assign sense_low = sync2_reg[5];
  assign sense_neg = sync2_reg[4];
  assign below_trip = sync2_reg[3];
  assign below_bat = sync2_reg[2];
  assign cs_in_n = sync2_reg[1];

  // internal oscillator sample tick
  logic [`TICK_W-1:0] div_reg, div_next;
  logic tick;
  assign tick = (div_reg == `TICK_W'(`OSC_DIV - 1));
  always_comb begin
    div_next = tick ? '0 : div_reg + `TICK_W'(1);
  end

  // pushbutton debounce and reset stretch
  logic [2:0] pb_cnt_reg, pb_cnt_next;
  logic pressed_reg, pressed_next;
  logic [`CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
  logic pb_enable;
  assign pb_enable = !below_bat && !(backed && sense_low);
  always_comb begin
    pb_cnt_next = pb_cnt_reg;
    pressed_next = pressed_reg;
    rst_cnt_next = rst_cnt_reg;
    if (!pb_enable) begin
      pb_cnt_next = '0;
      pressed_next = 1'b0;
    end else if (tick) begin
      if (!pb_n) begin
        if (pb_cnt_reg != 3'(`PB_SAMPLES))
          pb_cnt_next = pb_cnt_reg + 3'd1;
        else
          pressed_next = 1'b1;
      end else begin
        pb_cnt_next = '0;
        if (pressed_reg) begin
          pressed_next = 1'b0;
          rst_cnt_next = `CNT_W'(`RST_TICKS);
        end
      end
    end
    if (tick && !pressed_reg && rst_cnt_reg != '0 && !(pressed_reg && pb_n))
      rst_cnt_next = (pb_enable && pressed_reg && pb_n) ? rst_cnt_next : rst_cnt_reg - `CNT_W'(1);
    if (pb_enable && tick && pressed_reg && pb_n)
      rst_cnt_next = `CNT_W'(`RST_TICKS);
  end

  // early warning filter and pulse
  logic [1:0] low_cnt_reg, low_cnt_next;
  logic warn_reg, warn_next;
  logic [`CNT_W-1:0] warn_cnt_reg, warn_cnt_next;
  logic armed_reg, armed_next;
  logic trip_d_reg, trip_d_next;
  logic [1:0] seal_cnt_reg, seal_cnt_next;
  logic neg_d_reg, neg_d_next;
  logic sealed_reg, sealed_next;
  always_comb begin
    low_cnt_next = low_cnt_reg;
    warn_next = warn_reg;
    warn_cnt_next = warn_cnt_reg;
    armed_next = armed_reg;
    trip_d_next = below_trip;
    // warning stays off until main supply first reaches trip
    if (!below_trip)
      armed_next = 1'b1;
    else if (below_bat)
      armed_next = 1'b0;
    if (tick) begin
      if (!sense_low || !armed_reg) begin
        low_cnt_next = '0;
      end else if (low_cnt_reg != 2'(`SENSE_SAMPLES)) begin
        low_cnt_next = low_cnt_reg + 2'd1;
        if (low_cnt_reg == 2'(`SENSE_SAMPLES - 1) && !warn_reg) begin
          warn_next = 1'b1;
          warn_cnt_next = `CNT_W'(`WARN_TICKS);
        end
      end
      if (warn_reg && warn_cnt_reg != '0)
        warn_cnt_next = warn_cnt_reg - `CNT_W'(1);
      if (warn_reg && warn_cnt_reg == '0)
        warn_next = 1'b0;
    end
    // a sense-started warning ends early when sense returns; a main-trip pulse runs its full timeout unless main falls below battery
    if (warn_reg && !sense_low && low_cnt_reg == 2'(`SENSE_SAMPLES))
      warn_next = 1'b0;
    // non-backed mode: main trip is the sense crossing when sense is the switched supply
    if (!backed && below_trip && !trip_d_reg && armed_reg && !warn_reg) begin
      warn_next = 1'b1;
      warn_cnt_next = `CNT_W'(`WARN_TICKS);
    end
    if (below_bat)
      warn_next = 1'b0;
  end

  // freshness seal: count below-ground pulses, leave on supply return
  always_comb begin
    neg_d_next = sense_neg;
    seal_cnt_next = seal_cnt_reg;
    sealed_next = sealed_reg;
    if (sense_neg && !neg_d_reg && !sealed_reg) begin
      if (seal_cnt_reg == 2'(`SEAL_PULSES - 1))
        sealed_next = 1'b1;
      seal_cnt_next = seal_cnt_reg + 2'd1;
    end
    // leave only on the return of the supply, so the seal survives until power is cycled
    if (sealed_reg && !below_bat && o_power_fail_flag) begin
      sealed_next = 1'b0;
      seal_cnt_next = '0;
    end
  end

  // ram chip select guard
  cs_state_type cs_reg, cs_next;
  logic [2:0] grace_reg, grace_next;
  logic cs_out_next;
  always_comb begin
    cs_next = cs_reg;
    grace_next = grace_reg;
    cs_out_next = 1'b1;
    case (cs_reg)
      CS_PASS: begin
        cs_out_next = cs_in_n;
        if (below_trip) begin
          cs_out_next = o_chip_sel_out_n;
          grace_next = 3'(`GRACE_TICKS);
          cs_next = o_chip_sel_out_n ? CS_LOCK : CS_GRACE;
        end
      end
      CS_GRACE: begin
        cs_out_next = o_chip_sel_out_n;
        if (tick && grace_reg != '0)
          grace_next = grace_reg - 3'd1;
        if (cs_in_n || grace_reg == '0) begin
          cs_out_next = 1'b1;
          cs_next = CS_LOCK;
        end
      end
      CS_LOCK: begin
        cs_out_next = 1'b1;
        if (!below_trip)
          cs_next = CS_PASS;
      end
      default: cs_next = CS_LOCK;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= '0;
      pb_cnt_reg <= '0;
      pressed_reg <= 1'b0;
      rst_cnt_reg <= '0;
      low_cnt_reg <= '0;
      warn_reg <= 1'b0;
      warn_cnt_reg <= '0;
      armed_reg <= 1'b0;
      trip_d_reg <= 1'b1;
      seal_cnt_reg <= '0;
      neg_d_reg <= 1'b0;
      sealed_reg <= 1'b0;
      cs_reg <= CS_LOCK;
      grace_reg <= '0;
      o_chip_sel_out_n <= 1'b1;
      o_reset <= 1'b0;
      o_reset_n <= 1'b1;
      o_warn_n <= 1'b1;
      o_warn_oe <= 1'b1;
      o_power_fail_flag <= 1'b1;
      o_power_fail_flag_n <= 1'b0;
      o_battery_sealed <= 1'b0;
    end else begin
      div_reg <= div_next;
      pb_cnt_reg <= pb_cnt_next;
      pressed_reg <= pressed_next;
      rst_cnt_reg <= rst_cnt_next;
      low_cnt_reg <= low_cnt_next;
      warn_reg <= warn_next;
      warn_cnt_reg <= warn_cnt_next;
      armed_reg <= armed_next;
      trip_d_reg <= trip_d_next;
      seal_cnt_reg <= seal_cnt_next;
      neg_d_reg <= neg_d_next;
      sealed_reg <= sealed_next;
      cs_reg <= cs_next;
      grace_reg <= grace_next;
      o_chip_sel_out_n <= cs_out_next;
      o_reset <= pressed_next || rst_cnt_next != '0;
      o_reset_n <= !(pressed_next || rst_cnt_next != '0);
      o_warn_n <= !warn_next;
      // floating saves battery when the processor is not backed
      o_warn_oe <= !(below_bat && !backed);
      o_power_fail_flag <= below_bat;
      o_power_fail_flag_n <= !below_bat;
      o_battery_sealed <= sealed_next;
    end
  end

  a_reset_follows_press: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    pressed_reg && pb_enable |=> o_reset && !o_reset_n)
    else $error("reset not active while pressed");
  a_stretch_loaded: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $fell(pressed_reg) && pb_enable |-> rst_cnt_reg == `CNT_W'(`RST_TICKS))
    else $error("stretch not loaded");
  a_pb_blocked: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (below_bat || (backed && sense_low)) |=> !pressed_reg)
    else $error("pushbutton not ignored");
  a_warn_filter: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(warn_reg) && backed |-> $past(low_cnt_reg) == 2'd2)
    else $error("warning without three samples");
  a_warn_release: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    warn_reg && !sense_low && low_cnt_reg == 2'd3 |=> !warn_reg)
    else $error("warning not released");
  a_warn_float: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    below_bat && !backed |=> !o_warn_oe)
    else $error("warning not floated");
  a_cs_pass: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    cs_reg == CS_PASS && !below_trip |=> o_chip_sel_out_n == $past(cs_in_n))
    else $error("chip select not passed");
  a_cs_lock: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    cs_reg == CS_LOCK |=> o_chip_sel_out_n)
    else $error("chip select not locked");
  a_pf_pair: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_power_fail_flag != o_power_fail_flag_n ##1 o_power_fail_flag == $past(below_bat))
    else $error("power fail outputs wrong");
  c_press: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(pressed_reg));
  c_warn: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(warn_reg));
  c_trip_pulse: cover property (@(posedge i_mclk) disable iff (!i_resetn) $rose(warn_reg) && !backed && !sense_low);
  c_grace: cover property (@(posedge i_mclk) disable iff (!i_resetn) cs_reg == CS_GRACE);
  c_seal: cover property (@(posedge i_mclk) disable iff (!i_resetn) $rose(sealed_reg));
endmodule : supply_supervisor

// file: shared/supervisor_consts.svh
// timing counts and counter widths for the supply supervisor
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH
`define CLK_HZ 10000000
`define OSC_HZ 30000
// mclk cycles per internal oscillator sample
`define OSC_DIV ((`CLK_HZ + `OSC_HZ - 1) / `OSC_HZ)
`define OSC_PERIOD_NS 33333
`define RST_STRETCH_MS 25
// least times round up to whole sample periods
`define RST_TICKS ((`RST_STRETCH_MS * 1000000 + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS)
`define WARN_PULSE_US 200
`define WARN_TICKS ((`WARN_PULSE_US * 1000 + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS)
`define SENSE_SAMPLES 3
`define PB_SAMPLES 4
`define SEAL_PULSES 3
// cycle grace before chip select is forced off; not given, plain default
`define GRACE_TICKS 3
`define CNT_W 10
`define TICK_W 16
`endif

// file: shared/supervisor_pkg.sv
// types for the supply supervisor
package supervisor_pkg;
  typedef enum logic [1:0] {
    CS_PASS = 2'b00,
    CS_GRACE = 2'b01,
    CS_LOCK = 2'b10
  } cs_state_type;
endpackage : supervisor_pkg

// file: bench/board_model.sv
// board-side model: pushbutton held low for whole ticks and the below-ground seal pulse source
`timescale 1ns/1ps
module board_model (
  // clock
  input wire logic i_mclk,
  // board pins
  output logic o_pushbutton_reset_n,
  output logic o_sense_neg
);
  localparam int TICK = 334;
  initial begin
    o_pushbutton_reset_n = 1'b1;
    o_sense_neg = 1'b0;
  end
  // button held low for n sample ticks; the pull-up returns it high on release
  task automatic press(input int n);
    @(negedge i_mclk);
    o_pushbutton_reset_n = 1'b0;
    repeat (n * TICK) @(negedge i_mclk);
    o_pushbutton_reset_n = 1'b1;
  endtask : press
  // pulses two ticks wide so each one survives the input sampling
  task automatic seal_pulses();
    repeat (3) begin
      @(negedge i_mclk);
      o_sense_neg = 1'b1;
      repeat (2 * TICK) @(negedge i_mclk);
      o_sense_neg = 1'b0;
      repeat (2 * TICK) @(negedge i_mclk);
    end
  endtask : seal_pulses
endmodule : board_model

// file: bench/tb_top.sv
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
module tb_top;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic mode = 1'b0;
  logic sense_low = 1'b0;
  logic below_trip = 1'b0;
  logic below_bat = 1'b0;
  logic cs_n = 1'b1;
  logic pb_n, sense_neg, rst, rst_n, warn_n, warn_oe, cs_out_n, pf, pf_n, sealed;
  int mismatches = 0;
  int n_tests = 0;
  always #50 i_mclk = ~i_mclk;
  board_model board_model_inst (.i_mclk(i_mclk), .o_pushbutton_reset_n(pb_n), .o_sense_neg(sense_neg));
  supply_supervisor supply_supervisor_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_pushbutton_reset_n(pb_n), .i_mode_select(mode),
    .i_sense_low(sense_low), .i_sense_neg(sense_neg), .i_main_below_trip(below_trip),
    .i_main_below_bat(below_bat), .i_chip_sel_n(cs_n), .o_reset(rst), .o_reset_n(rst_n),
    .o_warn_n(warn_n), .o_warn_oe(warn_oe), .o_chip_sel_out_n(cs_out_n),
    .o_power_fail_flag(pf), .o_power_fail_flag_n(pf_n), .o_battery_sealed(sealed));
  task automatic cl(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cl
  // whole sample ticks of the internal oscillator
  task automatic tk(input int n);
    cl(n * 334);
  endtask : tk
  task automatic check(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask : check
  task automatic do_reset();
    i_resetn = 1'b0;
    cl(16);
    i_resetn = 1'b1;
    cl(4);
  endtask : do_reset
  task automatic t_chip_select();
    mode = 1'b1; // backed mode keeps the main-trip warning pulse out of this test
    cs_n = 1'b0;
    cl(4);
    check("cs pass low", 1'b0, cs_out_n);
    below_trip = 1'b1;
    cl(4);
    check("cs held in cycle", 1'b0, cs_out_n);
    cs_n = 1'b1;
    cl(4);
    check("cs protect", 1'b1, cs_out_n);
    cs_n = 1'b0;
    cl(4);
    check("cs locked", 1'b1, cs_out_n);
    below_trip = 1'b0;
    cl(4);
    check("cs follows again", 1'b0, cs_out_n);
    below_trip = 1'b1;
    tk(5);
    check("cs grace expiry", 1'b1, cs_out_n);
    below_trip = 1'b0;
    cs_n = 1'b1;
    cl(4);
    check("cs pass high", 1'b1, cs_out_n);
    mode = 1'b0;
    $display("test chip_select done");
  endtask : t_chip_select
  task automatic t_warning();
    sense_low = 1'b1;
    tk(2);
    sense_low = 1'b0;
    tk(1);
    check("warn two samples", 1'b1, warn_n);
    sense_low = 1'b1;
    tk(5);
    check("warn tripped", 1'b0, warn_n);
    tk(4);
    check("warn least width", 1'b0, warn_n);
    tk(3);
    check("warn timeout", 1'b1, warn_n);
    sense_low = 1'b0;
    tk(1);
    sense_low = 1'b1;
    tk(4);
    check("warn second", 1'b0, warn_n);
    sense_low = 1'b0;
    tk(1);
    cl(4);
    check("warn early end", 1'b1, warn_n);
    $display("test warning done");
  endtask : t_warning
  task automatic t_power_fail();
    below_bat = 1'b1;
    cl(4);
    check("pf high", 1'b1, pf);
    check("pf_n low", 1'b0, pf_n);
    check("warn float", 1'b0, warn_oe);
    mode = 1'b1;
    cl(4);
    check("warn driven", 1'b1, warn_oe);
    check("warn held high", 1'b1, warn_n);
    below_bat = 1'b0;
    mode = 1'b0;
    cl(4);
    check("pf low", 1'b0, pf);
    check("pf_n high", 1'b1, pf_n);
    $display("test power_fail done");
  endtask : t_power_fail
  task automatic t_pb_ignored();
    below_bat = 1'b1;
    board_model_inst.press(8);
    tk(1);
    check("pb below battery", 1'b0, rst);
    below_bat = 1'b0;
    mode = 1'b1;
    sense_low = 1'b1;
    board_model_inst.press(8);
    tk(1);
    check("pb backed sense low", 1'b0, rst);
    sense_low = 1'b0;
    mode = 1'b0;
    tk(8);
    $display("test pb_ignored done");
  endtask : t_pb_ignored
  task automatic t_seal();
    board_model_inst.seal_pulses();
    cl(4);
    check("sealed", 1'b1, sealed);
    below_bat = 1'b1;
    cl(4);
    below_bat = 1'b0;
    cl(4);
    check("seal left", 1'b0, sealed);
    $display("test seal done");
  endtask : t_seal
  task automatic t_trip_modes();
    below_trip = 1'b1;
    tk(4);
    check("nonbacked trip pulse", 1'b0, warn_n);
    tk(8);
    below_trip = 1'b0;
    mode = 1'b1;
    tk(1);
    below_trip = 1'b1;
    tk(4);
    check("backed no pulse", 1'b1, warn_n);
    below_trip = 1'b0;
    tk(1);
    // power-up with main below trip: a low sense must stay masked
    i_resetn = 1'b0;
    below_trip = 1'b1;
    cl(16);
    i_resetn = 1'b1;
    sense_low = 1'b1;
    tk(8);
    check("powerup mask", 1'b1, warn_n);
    sense_low = 1'b0;
    below_trip = 1'b0;
    mode = 1'b0;
    tk(2);
    $display("test trip_modes done");
  endtask : t_trip_modes
  task automatic t_pushbutton();
    board_model_inst.press(2);
    tk(1);
    check("bounce ignored", 1'b0, rst);
    fork
      board_model_inst.press(10);
      begin
        tk(8);
        check("reset while pressed", 1'b1, rst);
      end
    join
    tk(20);
    check("reset after release", 1'b1, rst);
    check("reset_n after release", 1'b0, rst_n);
    $display("test pushbutton done");
  endtask : t_pushbutton
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    do_reset();
    t_chip_select();
    t_warning();
    t_power_fail();
    t_pb_ignored();
    t_seal();
    t_trip_modes();
    t_pushbutton();
    tally_and_finish();
  end
endmodule : tb_top
